// ### common/dcsr_pkg.sv
// Package: register map, status codes and timing for the status reporter
package dcsr_pkg;
  // Register indices (byte address = 4 * index)
  localparam logic [3:0] REG_DRIVE_SEL = 4'h0;
  localparam logic [3:0] REG_HEAD_CYL_HI = 4'h1;
  localparam logic [3:0] REG_CYL_LO = 4'h2;
  localparam logic [3:0] REG_SECT_CNT = 4'h3;
  localparam logic [3:0] REG_COMMAND = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_RESULT0 = 4'h6;
  localparam logic [3:0] REG_RESULT1 = 4'h7;
  localparam logic [3:0] REG_RESULT2 = 4'h8;
  localparam logic [3:0] REG_RESULT3 = 4'h9;
  localparam logic [3:0] REG_RESULT4 = 4'hA;
  localparam logic [3:0] REG_LIMITS = 4'hB;
  localparam logic [3:0] REG_ACK = 4'hC;
  // Field positions
  localparam int DRV_HI = 7;
  localparam int DRV_LO = 6;
  localparam int TYPE_HI = 5;
  localparam int TYPE_LO = 4;
  localparam int HEAD_HI = 6;
  localparam int HEAD_LO = 4;
  localparam int CYLH_HI = 3;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_MAX_HEAD = 3'h7;
  localparam logic [11:0] RST_MAX_CYL = 12'h3FF;
  // Command codes
  localparam logic [7:0] CMD_ACK = 8'h00;
  localparam logic [7:0] CMD_READ = 8'h53;
  localparam logic [7:0] CMD_WRITE = 8'h52;
  localparam logic [7:0] CMD_READ_PHYS = 8'h59;
  localparam logic [7:0] CMD_SEQ_UP = 8'h83;
  localparam logic [7:0] CMD_DIAG = 8'h8F;
  // Transaction status codes (bits 5-0)
  localparam logic [5:0] ST_OK = 6'h00;
  localparam logic [5:0] ST_DRV_FAULT = 6'h13;
  localparam logic [5:0] ST_LOSS_SYNC = 6'h19;
  localparam logic [5:0] ST_RAM_FAIL = 6'h1A;
  localparam logic [5:0] ST_IDBUF_FAIL = 6'h1B;
  localparam logic [5:0] ST_NOT_READY = 6'h20;
  localparam logic [5:0] ST_WPROT = 6'h21;
  localparam logic [5:0] ST_NOT_PRESENT = 6'h22;
  localparam logic [5:0] ST_SECT_SIZE = 6'h23;
  localparam logic [5:0] ST_ALT_OVFL = 6'h24;
  localparam logic [5:0] ST_SECT_NF = 6'h30;
  localparam logic [5:0] ST_CMD_REJ = 6'h31;
  localparam logic [5:0] ST_DRV_TMO = 6'h32;
  localparam logic [5:0] ST_XFER_TMO = 6'h33;
  localparam logic [5:0] ST_ILL_CH = 6'h34;
  localparam logic [5:0] ST_BAD_DRIVE = 6'h35;
  localparam logic [5:0] ST_PHYS_NF = 6'h36;
  localparam logic [5:0] ST_IN_PROG = 6'h37;
  localparam logic [5:0] ST_DBL_WRITE = 6'h38;
  localparam logic [5:0] ST_DRV_REJ = 6'h39;
  localparam logic [5:0] ST_MULTI_ERR = 6'h3A;
  localparam logic [7:0] MAX_SECT_CNT = 8'h7F;
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int XFER_LIMIT_S = 3;
  localparam longint XFER_CYCLES = longint'(XFER_LIMIT_S) * CLK_MHZ * 1000000;
  localparam int SPINUP_LIMIT_MS = 1000;
  localparam longint SPINUP_CYCLES =
    longint'(SPINUP_LIMIT_MS) * CLK_MHZ * 1000;
  typedef enum logic [1:0] {DC_IDLE, DC_BUSY, DC_DONE} dcsr_state_t;
endpackage

// ### hdl/dcsr_status.sv
// Command check and transaction status encoder with Wishbone registers
//
// Contract
// - Status byte: drive in bits 7-6, type 5-4, code 3-0.
// - Read ending short of expected bytes reports loss of sync.
// - Bad memory: report failure, expected, received, address high, low.
// - Identifier buffer error: status 1B with expected, received, location.
// - Drive not ready after spin-up within allowed time gives 20.
// - Write to write-protected drive gives 21.
// - Absent or unpowered drive gives 22.
// - Invalid sector-size switch setting gives 23.
// - More defects than spares gives 24.
// - Logical sector not found gives 30.
// - Unsupported command code gives 31.
// - Drive not completing issued command gives 32.
// - Transfer unfinished in three seconds aborts with 33.
// - Head or cylinder above drive maximum gives 34.
// - Drive number above three gives 35.
// - Physical operation missing its sector gives 36.
// - Command to drive already busy gives 37.
// - Command write while busy gives 38; host must wait.
// - Controller or drive hardware failure gives 39.
// - Read/write count zero or above 7F gives 3A.
// - Any of seven drive fault conditions ends with drive fault.
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module dcsr_status
  import dcsr_pkg::*;
#(
  parameter longint XFER_TIMEOUT = XFER_CYCLES,
  parameter longint SPINUP_TIMEOUT = SPINUP_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Drive side conditions (presence and busy for each of four drives, the rest for the addressed drive)
  input wire logic [3:0] drivePresent,
  input wire logic [3:0] driveBusyIn,
  input wire logic driveReady,
  input wire logic driveWriteProt,
  input wire logic sectSizeBad,
  input wire logic altOverflow,
  input wire logic sectNotFound,
  input wire logic driveCmdDone,
  input wire logic hwFailure,
  input wire logic xferDone,
  input wire logic readEndedShort,
  input wire logic [6:0] faultCond,
  input wire logic diagDone,
  input wire logic diagRamBad,
  input wire logic diagIdBad,
  input wire logic [7:0] diagExpected,
  input wire logic [7:0] diagReceived,
  input wire logic [15:0] diagAddr,
  output logic ctrlBusy,
  output logic completionReq
);
  logic [7:0] driveSel, headCylHi, cylLo, sectCnt, cmdReg, maxCylHi;
  logic [2:0] maxHead;
  logic [7:0] limCylLo;
  logic [7:0] result [0:4];
  logic [63:0] timer;
  dcsr_state_t state;
  logic wbReq, wbWr, cmdWrite;
  logic [5:0] next_status;
  logic finish;
  logic [7:0] next_r1, next_r2, next_r3, next_r4;

  function automatic logic isKnown(input logic [7:0] c);
    isKnown = c == CMD_READ || c == CMD_WRITE || c == CMD_READ_PHYS ||
              c == CMD_SEQ_UP || c == CMD_DIAG;
  endfunction
  function automatic logic isData(input logic [7:0] c);
    isData = c == CMD_READ || c == CMD_WRITE;
  endfunction

  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wbWr = wbReq && wb_we_i && wb_sel_i[0];
  assign cmdWrite = wbWr && wb_adr_i[5:2] == REG_COMMAND;

  // Wishbone slave: one wait state, err on unmapped index
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wbReq && wb_adr_i[5:2] <= REG_ACK;
      wb_err_o <= wbReq && wb_adr_i[5:2] > REG_ACK;
      wb_dat_o <= 32'h0000_0000;
      if (wbReq && !wb_we_i) begin
        case (wb_adr_i[5:2])
          REG_STATUS: wb_dat_o[1:0] <= {completionReq, ctrlBusy};
          REG_RESULT0: wb_dat_o[7:0] <= result[0];
          REG_RESULT1: wb_dat_o[7:0] <= result[1];
          REG_RESULT2: wb_dat_o[7:0] <= result[2];
          REG_RESULT3: wb_dat_o[7:0] <= result[3];
          REG_RESULT4: wb_dat_o[7:0] <= result[4];
          REG_LIMITS: wb_dat_o[14:0] <= {maxHead, maxCylHi[3:0], limCylLo};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Drive, head/cylinder and count registers are write only; the limits register reads back
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      driveSel <= RST_BYTE;
      headCylHi <= RST_BYTE;
      cylLo <= RST_BYTE;
      sectCnt <= RST_BYTE;
      maxHead <= RST_MAX_HEAD;
      maxCylHi <= {4'h0, RST_MAX_CYL[11:8]};
      limCylLo <= RST_MAX_CYL[7:0];
    end else if (wbWr) begin
      case (wb_adr_i[5:2])
        REG_DRIVE_SEL: driveSel <= wb_dat_i[7:0];
        REG_HEAD_CYL_HI: headCylHi <= wb_dat_i[7:0];
        REG_CYL_LO: cylLo <= wb_dat_i[7:0];
        REG_SECT_CNT: sectCnt <= wb_dat_i[7:0];
        REG_LIMITS: begin
          maxHead <= wb_dat_i[14:12];
          maxCylHi <= {4'h0, wb_dat_i[11:8]};
          limCylLo <= wb_dat_i[7:0];
        end
        default: ;
      endcase
    end
  end

  // Parameter checks at command write
  logic [5:0] checkStatus;
  logic [11:0] cylTarget, cylMax;
  assign cylTarget = {headCylHi[CYLH_HI:0], cylLo};
  assign cylMax = {maxCylHi[3:0], limCylLo};
  always_comb begin
    checkStatus = ST_OK;
    if (!isKnown(wb_dat_i[7:0]))
      checkStatus = ST_CMD_REJ;
    else if (driveSel > 8'h03)
      checkStatus = ST_BAD_DRIVE;
    else if (!drivePresent[driveSel[1:0]])
      checkStatus = ST_NOT_PRESENT;
    else if (driveBusyIn[driveSel[1:0]])
      checkStatus = ST_IN_PROG;
    else if (isData(wb_dat_i[7:0]) &&
             (sectCnt == 8'h00 || sectCnt > MAX_SECT_CNT))
      checkStatus = ST_MULTI_ERR;
    else if (headCylHi[HEAD_HI:HEAD_LO] > maxHead || cylTarget > cylMax)
      checkStatus = ST_ILL_CH;
    else if (wb_dat_i[7:0] == CMD_WRITE && driveWriteProt)
      checkStatus = ST_WPROT;
    else if (sectSizeBad)
      checkStatus = ST_SECT_SIZE;
  end

  // Completion detection while a command runs
  always_comb begin
    finish = 1'b0;
    next_status = ST_OK;
    next_r1 = RST_BYTE;
    next_r2 = RST_BYTE;
    next_r3 = RST_BYTE;
    next_r4 = RST_BYTE;
    if (state == DC_BUSY) begin
      finish = 1'b1;
      if (|faultCond)
        next_status = ST_DRV_FAULT;
      else if (hwFailure)
        next_status = ST_DRV_REJ;
      else if (cmdReg == CMD_DIAG && diagDone && diagRamBad) begin
        next_status = ST_RAM_FAIL;
        next_r1 = diagExpected;
        next_r2 = diagReceived;
        next_r3 = diagAddr[15:8];
        next_r4 = diagAddr[7:0];
      end else if (cmdReg == CMD_DIAG && diagDone && diagIdBad) begin
        next_status = ST_IDBUF_FAIL;
        next_r1 = diagExpected;
        next_r2 = diagReceived;
        next_r3 = diagAddr[7:0];
      end else if (cmdReg == CMD_DIAG)
        finish = diagDone;
      else if (cmdReg == CMD_SEQ_UP) begin
        if (driveReady)
          next_status = ST_OK;
        else if (timer >= 64'(SPINUP_TIMEOUT) - 64'd1)
          next_status = ST_NOT_READY;
        else
          finish = 1'b0;
      end else if (altOverflow)
        next_status = ST_ALT_OVFL;
      else if (sectNotFound)
        next_status = cmdReg == CMD_READ_PHYS ? ST_PHYS_NF : ST_SECT_NF;
      else if (cmdReg == CMD_READ && readEndedShort)
        next_status = ST_LOSS_SYNC;
      else if (xferDone && !driveCmdDone)
        next_status = ST_DRV_TMO;
      else if (xferDone)
        next_status = ST_OK;
      else if (timer >= 64'(XFER_TIMEOUT) - 64'd1)
        next_status = ST_XFER_TMO;
      else
        finish = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      timer <= 64'd0;
    else if (state != DC_BUSY)
      timer <= 64'd0;
    else
      timer <= timer + 64'd1;
  end

  // Sequencer, busy, completion and results
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= DC_IDLE;
      cmdReg <= RST_BYTE;
      ctrlBusy <= 1'b0;
      completionReq <= 1'b0;
      for (int i = 0; i < 5; i++) result[i] <= RST_BYTE;
    end else begin
      case (state)
        DC_IDLE, DC_DONE: begin
          if (cmdWrite && wb_dat_i[7:0] == CMD_ACK) begin
            completionReq <= 1'b0;
            state <= DC_IDLE;
          end else if (cmdWrite) begin
            cmdReg <= wb_dat_i[7:0];
            if (checkStatus != ST_OK) begin
              result[0] <= {driveSel[1:0], checkStatus};
              for (int i = 1; i < 5; i++) result[i] <= RST_BYTE;
              completionReq <= 1'b1;
              state <= DC_DONE;
            end else begin
              ctrlBusy <= 1'b1;
              completionReq <= 1'b0;
              state <= DC_BUSY;
            end
          end
        end
        DC_BUSY: begin
          if (cmdWrite) begin
            // Busy command write is refused; the running command continues
            result[0] <= {driveSel[1:0], ST_DBL_WRITE};
            completionReq <= 1'b1;
          end else if (finish) begin
            result[0] <= {driveSel[1:0], next_status};
            result[1] <= next_r1;
            result[2] <= next_r2;
            result[3] <= next_r3;
            result[4] <= next_r4;
            ctrlBusy <= 1'b0;
            completionReq <= 1'b1;
            state <= DC_DONE;
          end
        end
        default: state <= DC_IDLE;
      endcase
    end
  end

  // Check helpers: a busy cycle with no fault, no hardware failure and no
  // command write, and a running command that moves data
  logic busyClean, dataCmd;
  assign busyClean = state == DC_BUSY && !cmdWrite && !(|faultCond) &&
                     !hwFailure;
  assign dataCmd = cmdReg != CMD_DIAG && cmdReg != CMD_SEQ_UP;

  a_status_layout: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $rose(completionReq) && $past(state) == DC_IDLE |->
      result[0][DRV_HI:DRV_LO] == $past(driveSel[1:0]))
    else $error("drive field mismatch");
  a_bad_drive: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmdWrite && state == DC_IDLE && isKnown(wb_dat_i[7:0]) &&
      driveSel > 8'h03 |=> result[0][5:0] == ST_BAD_DRIVE)
    else $error("drive number check missed");
  a_bad_cmd: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmdWrite && state == DC_IDLE && wb_dat_i[7:0] != CMD_ACK &&
      !isKnown(wb_dat_i[7:0]) |=> result[0][5:0] == ST_CMD_REJ ##0
      completionReq)
    else $error("unsupported command accepted");
  a_not_present: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmdWrite && state == DC_IDLE && isKnown(wb_dat_i[7:0]) &&
      driveSel <= 8'h03 && !drivePresent[driveSel[1:0]] |=>
      result[0][5:0] == ST_NOT_PRESENT)
    else $error("absent drive not reported");
  a_in_progress: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmdWrite && state == DC_IDLE && isKnown(wb_dat_i[7:0]) &&
      driveSel <= 8'h03 && drivePresent[driveSel[1:0]] &&
      driveBusyIn[driveSel[1:0]] |=> result[0][5:0] == ST_IN_PROG)
    else $error("busy drive not reported");
  a_limits_kept: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $rose(ctrlBusy) |->
      $past(headCylHi[HEAD_HI:HEAD_LO]) <= $past(maxHead) &&
      $past(cylTarget) <= $past(cylMax))
    else $error("command started beyond drive limits");
  a_double_write: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmdWrite && state == DC_BUSY |=> result[0][5:0] == ST_DBL_WRITE)
    else $error("double write not reported");
  a_fault_ends: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state == DC_BUSY && |faultCond && !cmdWrite |=>
      !ctrlBusy && result[0][5:0] == ST_DRV_FAULT)
    else $error("drive fault not reported");
  a_hw_reject: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state == DC_BUSY && !cmdWrite && hwFailure && !(|faultCond) |=>
      !ctrlBusy && result[0][5:0] == ST_DRV_REJ)
    else $error("hardware failure not reported");
  a_busy_mirror: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ctrlBusy == (state == DC_BUSY))
    else $error("busy flag disagrees with state");
  a_multi_cnt: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmdWrite && state == DC_IDLE && checkStatus == ST_MULTI_ERR |=>
      state == DC_DONE && result[0][5:0] == ST_MULTI_ERR)
    else $error("sector count error missed");
  a_spinup_tmo: assert property (
    @(posedge mclk) disable iff (!rst_n)
    busyClean && cmdReg == CMD_SEQ_UP && !driveReady &&
      timer == 64'(SPINUP_TIMEOUT) - 64'd1 |=>
      !ctrlBusy && result[0][5:0] == ST_NOT_READY)
    else $error("spin-up timeout not reported");
  a_xfer_tmo: assert property (
    @(posedge mclk) disable iff (!rst_n)
    busyClean && dataCmd && !xferDone && !altOverflow && !sectNotFound &&
      !readEndedShort && timer == 64'(XFER_TIMEOUT) - 64'd1 |=>
      !ctrlBusy && result[0][5:0] == ST_XFER_TMO)
    else $error("transfer timeout not reported");
  a_alt_ovfl: assert property (
    @(posedge mclk) disable iff (!rst_n)
    busyClean && dataCmd && altOverflow |=> result[0][5:0] == ST_ALT_OVFL)
    else $error("spare overflow not reported");
  a_sect_missing: assert property (
    @(posedge mclk) disable iff (!rst_n)
    busyClean && dataCmd && sectNotFound && !altOverflow |=>
      result[0][5:0] == (cmdReg == CMD_READ_PHYS ? ST_PHYS_NF : ST_SECT_NF))
    else $error("missing sector not reported");
  a_loss_sync: assert property (
    @(posedge mclk) disable iff (!rst_n)
    busyClean && cmdReg == CMD_READ && readEndedShort && !altOverflow &&
      !sectNotFound |=> result[0][5:0] == ST_LOSS_SYNC)
    else $error("short read not reported");
  a_drive_tmo: assert property (
    @(posedge mclk) disable iff (!rst_n)
    busyClean && dataCmd && xferDone && !driveCmdDone && !altOverflow &&
      !sectNotFound && !readEndedShort |=> result[0][5:0] == ST_DRV_TMO)
    else $error("unfinished drive command not reported");
  a_ram_result: assert property (
    @(posedge mclk) disable iff (!rst_n)
    busyClean && cmdReg == CMD_DIAG && diagDone && diagRamBad |=>
      result[0][5:0] == ST_RAM_FAIL && result[2] == $past(diagReceived) &&
      result[3] == $past(diagAddr[15:8]) && result[4] == $past(diagAddr[7:0]))
    else $error("memory failure results wrong");
  a_id_result: assert property (
    @(posedge mclk) disable iff (!rst_n)
    busyClean && cmdReg == CMD_DIAG && diagDone && diagIdBad &&
      !diagRamBad |=> result[0][5:0] == ST_IDBUF_FAIL &&
      result[1] == $past(diagExpected) && result[3] == $past(diagAddr[7:0]))
    else $error("identifier buffer results wrong");
endmodule

// ### tb/dcsr_host.sv
// Wishbone host model issuing disc commands through the parameter registers
`timescale 1ns/100ps
module dcsr_host
  import dcsr_pkg::*;
(
  input wire logic mclk,
  input wire logic ack,
  input wire logic err,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [5:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 6'h00;
    sel = 4'h0;
    dat = 32'h0000_0000;
  end

  task automatic xfer(input logic w, input logic [3:0] idx,
                      input logic [7:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'h1;
    dat <= {24'h00_0000, d};
    do @(posedge mclk); while (ack !== 1'b1 && err !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // Inverted on release so a stale byte never passes for a fresh one
    dat <= ~dat;
  endtask

  task automatic sendCmd(input logic [7:0] drv, input logic [7:0] hc,
                         input logic [7:0] cl, input logic [7:0] cnt,
                         input logic [7:0] code);
    xfer(1'b1, REG_DRIVE_SEL, drv);
    xfer(1'b1, REG_HEAD_CYL_HI, hc);
    xfer(1'b1, REG_CYL_LO, cl);
    xfer(1'b1, REG_SECT_CNT, cnt);
    xfer(1'b1, REG_COMMAND, code);
  endtask
endmodule

// ### tb/disc_command_status_reporter_bench.sv
// Self-checking bench for the command status reporter
`timescale 1ns/100ps
module disc_command_status_reporter_bench import dcsr_pkg::*;;
  localparam int LIMIT = 20000;
  // Row: code, drive byte, head/cyl hi, count, condition mask, status
  localparam logic [49:0] TBL [18] = '{
    {8'h77, 8'h00, 8'h00, 8'h01, 12'h000, ST_CMD_REJ},
    {CMD_READ, 8'h04, 8'h00, 8'h01, 12'h000, ST_BAD_DRIVE},
    {CMD_READ, 8'h02, 8'h00, 8'h01, 12'h000, ST_NOT_PRESENT},
    {CMD_READ, 8'h03, 8'h00, 8'h01, 12'h000, ST_IN_PROG},
    {CMD_READ, 8'h01, 8'h00, 8'h00, 12'h000, ST_MULTI_ERR},
    {CMD_WRITE, 8'h01, 8'h00, 8'h80, 12'h000, ST_MULTI_ERR},
    {CMD_READ, 8'h01, 8'h04, 8'h01, 12'h000, ST_ILL_CH},
    {CMD_WRITE, 8'h01, 8'h00, 8'h01, 12'h040, ST_WPROT},
    {CMD_READ, 8'h01, 8'h00, 8'h01, 12'h080, ST_SECT_SIZE},
    {CMD_READ, 8'h01, 8'h00, 8'h01, 12'h001, ST_DRV_REJ},
    {CMD_READ, 8'h01, 8'h00, 8'h01, 12'h002, ST_ALT_OVFL},
    {CMD_READ, 8'h01, 8'h00, 8'h01, 12'h004, ST_SECT_NF},
    {CMD_READ_PHYS, 8'h01, 8'h00, 8'h01, 12'h004, ST_PHYS_NF},
    {CMD_READ, 8'h01, 8'h00, 8'h7F, 12'h008, ST_LOSS_SYNC},
    {CMD_READ, 8'h01, 8'h00, 8'h01, 12'h010, ST_DRV_TMO},
    {CMD_WRITE, 8'h01, 8'h73, 8'h7F, 12'h030, ST_OK},
    {CMD_READ, 8'h01, 8'h00, 8'h01, 12'h000, ST_XFER_TMO},
    {CMD_SEQ_UP, 8'h01, 8'h00, 8'h01, 12'h400, ST_NOT_READY}
  };
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] cond = 12'h000;
  logic [6:0] faultCond = 7'h00;
  logic [7:0] dExp = 8'h00;
  logic [7:0] dRcv = 8'h00;
  logic [15:0] dAddr = 16'h0000;
  logic cyc, stb, we, wbAck, wbErr, ctrlBusy, completionReq;
  logic [5:0] adr;
  logic [3:0] sel;
  logic [31:0] datW, datR;
  logic [8:0] expQ [$];
  logic [8:0] e;
  logic [7:0] xe, xr;
  logic [15:0] xa;
  int mismatches = 0;
  int nTests = 0;
  int cycles = 0;

  always #2 mclk = ~mclk;

  dcsr_status #(.XFER_TIMEOUT(40), .SPINUP_TIMEOUT(20)) u_dcsr_status (
    .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW),
    .wb_dat_o(datR), .wb_ack_o(wbAck), .wb_err_o(wbErr),
    .drivePresent(4'hB), .driveBusyIn(4'h8), .driveReady(!cond[10]),
    .driveWriteProt(cond[6]), .sectSizeBad(cond[7]),
    .altOverflow(cond[1]), .sectNotFound(cond[2]),
    .driveCmdDone(cond[5]), .hwFailure(cond[0]), .xferDone(cond[4]),
    .readEndedShort(cond[3]), .faultCond(faultCond),
    .diagDone(cond[11]), .diagRamBad(cond[8]), .diagIdBad(cond[9]),
    .diagExpected(dExp), .diagReceived(dRcv), .diagAddr(dAddr),
    .ctrlBusy(ctrlBusy), .completionReq(completionReq));

  dcsr_host u_dcsr_host (.mclk(mclk), .ack(wbAck), .err(wbErr),
    .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(datW));

  task automatic check(input string what, input logic [8:0] seen,
                       input logic [8:0] exp);
    nTests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    if (mismatches == 0 && nTests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Each read answer is matched against the oldest noted expectation
  always @(posedge mclk) begin
    if (cyc && !we && (wbAck || wbErr)) begin
      e = expQ.pop_front();
      if (e[8]) check("bus error", {wbErr, 8'h00}, 9'h100);
      else check("read byte", {wbErr, datR[7:0]}, e);
    end
  end

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic expect8(input logic [3:0] idx, input logic [7:0] v);
    expQ.push_back({1'b0, v});
    u_dcsr_host.xfer(1'b0, idx, 8'h00);
  endtask

  task automatic waitDone;
    do @(negedge mclk); while (completionReq !== 1'b1 || ctrlBusy !== 1'b0);
  endtask

  task automatic runRow(input logic [49:0] r);
    cond <= r[17:6];
    u_dcsr_host.sendCmd(r[41:34], r[33:26], 8'($urandom), r[25:18],
                        r[49:42]);
    waitDone();
    expect8(REG_RESULT0, {r[35:34], r[5:0]});
  endtask

  task automatic finishCmd;
    cond <= 12'h000;
    faultCond <= 7'h00;
    u_dcsr_host.xfer(1'b1, REG_COMMAND, CMD_ACK);
    expect8(REG_STATUS, 8'h00);
    check("done pins", {7'h00, completionReq, ctrlBusy}, 9'h000);
  endtask

  initial begin
    void'($urandom(32'hf1b6_5360));
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    expect8(REG_LIMITS, 8'hFF);
    expQ.push_back(9'h100);
    u_dcsr_host.xfer(1'b0, 4'hD, 8'h00);
    foreach (TBL[i]) begin
      runRow(TBL[i]);
      finishCmd();
    end
    for (int i = 0; i < 7; i++) begin
      faultCond <= 7'(1 << i);
      runRow({CMD_READ, 8'h01, 8'h00, 8'h01, 12'h000, ST_DRV_FAULT});
      finishCmd();
    end
    for (int k = 0; k < 2; k++) begin
      xe = 8'($urandom);
      xr = 8'($urandom);
      xa = 16'($urandom);
      dExp <= xe;
      dRcv <= xr;
      dAddr <= xa;
      runRow({CMD_DIAG, 8'h00, 8'h00, 8'h01, k ? 12'hA00 : 12'h900,
              k ? ST_IDBUF_FAIL : ST_RAM_FAIL});
      expect8(REG_RESULT1, xe);
      expect8(REG_RESULT2, xr);
      expect8(REG_RESULT3, k ? xa[7:0] : xa[15:8]);
      if (k == 0) expect8(REG_RESULT4, xa[7:0]);
      finishCmd();
    end
    cond <= 12'h000;
    u_dcsr_host.sendCmd(8'h01, 8'h00, 8'h00, 8'h01, CMD_READ);
    expect8(REG_STATUS, 8'h01);
    u_dcsr_host.xfer(1'b1, REG_COMMAND, CMD_READ);
    check("busy pins", {7'h00, completionReq, ctrlBusy}, 9'h003);
    expect8(REG_RESULT0, {2'b01, ST_DBL_WRITE});
    cond <= 12'h030;
    waitDone();
    expect8(REG_RESULT0, {2'b01, ST_OK});
    finishCmd();
    tally_and_finish();
  end
endmodule
